// [logic/pcw_pkg.sv]
// Purpose: shared constants for the pulse-count single wire link
// Assumes: 25 MHz system clock on both ends
// Notes: timing figures in microseconds, cycle counts derived from them
package pcw_pkg;
    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int CLK_MHZ = 25;
    localparam int ENABLE_SETUP_US = 100;
    localparam int SHUTDOWN_LOW_US = 3000;
    localparam int ADDR_HOLD_MIN_US = 500;
    localparam int ADDR_HOLD_MAX_US = 1000;
    localparam int DATA_HOLD_US = 1000;
    localparam int BUS_RESET_US = 2000;
    localparam int STANDBY_US = 10000;
    localparam int PULSE_HALF_US = 10;
    // least times round up
    localparam int ENABLE_SETUP_CYC = ENABLE_SETUP_US * CLK_MHZ;
    localparam int SHUTDOWN_LOW_CYC = SHUTDOWN_LOW_US * CLK_MHZ;
    localparam int ADDR_HOLD_MIN_CYC = ADDR_HOLD_MIN_US * CLK_MHZ;
    localparam int ADDR_HOLD_MAX_CYC = ADDR_HOLD_MAX_US * CLK_MHZ;
    localparam int DATA_HOLD_CYC = DATA_HOLD_US * CLK_MHZ;
    localparam int BUS_RESET_CYC = BUS_RESET_US * CLK_MHZ;
    localparam int STANDBY_CYC = STANDBY_US * CLK_MHZ;
    localparam int PULSE_HALF_CYC = PULSE_HALF_US * CLK_MHZ;
    localparam int TIMER_W = 20;

    // ****************************************************************
    // fields
    // ****************************************************************
    localparam int ADDR_W = 5;
    localparam int DATA_W = 6;
    localparam int NUM_REGS = 32;
    localparam int NUM_LEDS = 6;
    localparam int LED_EN_ADDR = 0;
    localparam logic [DATA_W-1:0] REG_RESET = 6'h00;
endpackage

// [logic/pcw_link_if.sv]
// Purpose: single wire between host and device
// Assumes: host is the only driver, push-pull
// Notes: wire level resolved here from the host enable, pulled up when idle
`timescale 1ns/1ps
interface pcw_link_if;
    logic wire_out;
    logic wire_oe;
    logic single_wire_pin;

    assign single_wire_pin = wire_oe ? wire_out : 1'b1;

    modport host (
        output wire_out,
        output wire_oe,
        input single_wire_pin
    );
    modport device (
        input single_wire_pin
    );
endinterface

// [logic/pcw_level_timer.sv]
// Purpose: measures how long a synchronised level has been stable
// Assumes: level input already on clk_sys_i
// Notes: saturates, restarts on every change of level
`timescale 1ns/1ps
module pcw_level_timer (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic level_i,
    output logic [pcw_pkg::TIMER_W-1:0] count_o,
    output logic edge_o
);
    logic prev_reg;
    logic prev_next;
    logic [pcw_pkg::TIMER_W-1:0] count_reg;
    logic [pcw_pkg::TIMER_W-1:0] count_next;

    always_comb begin
        prev_next = level_i;
        if (level_i != prev_reg) begin
            count_next = '0;
        end else if (count_reg != {pcw_pkg::TIMER_W{1'b1}}) begin
            count_next = count_reg + 1'b1;
        end else begin
            count_next = count_reg;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            // same level as the synchroniser reset, so no false edge follows reset
            prev_reg <= 1'b0;
            count_reg <= '0;
        end else begin
            prev_reg <= prev_next;
            count_reg <= count_next;
        end
    end

    assign count_o = count_reg;
    assign edge_o = level_i != prev_reg;
endmodule

// [logic/pcw_device.sv]
// Purpose: device end: decodes pulse bursts into register writes
// Assumes: host keeps pulse widths within their maxima
// Notes: registers reset when the wire is held low past shutdown time
`timescale 1ns/1ps

module pcw_device (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    pcw_link_if.device link,
    input wire logic overtemp_i,
    input wire logic [pcw_pkg::NUM_LEDS-1:0] led_open_i,
    output logic chip_enabled_o,
    output logic sleep_o,
    output logic standby_o,
    output logic [pcw_pkg::NUM_LEDS-1:0] led_drive_o,
    output logic write_stb_o,
    output logic [pcw_pkg::ADDR_W-1:0] write_addr_o,
    output logic [pcw_pkg::DATA_W-1:0] write_data_o
);
    // ****************************************************************
    // pin synchroniser and level timing
    // ****************************************************************
    typedef enum {
        PCW_OFF,
        PCW_ADDR,
        PCW_DATA,
        PCW_WAIT_RESET
    } pcw_dev_state_t;

    localparam logic [pcw_pkg::TIMER_W-1:0] SETUP_T =
        pcw_pkg::TIMER_W'(pcw_pkg::ENABLE_SETUP_CYC);
    localparam logic [pcw_pkg::TIMER_W-1:0] SHUT_T =
        pcw_pkg::TIMER_W'(pcw_pkg::SHUTDOWN_LOW_CYC);
    localparam logic [pcw_pkg::TIMER_W-1:0] AMIN_T =
        pcw_pkg::TIMER_W'(pcw_pkg::ADDR_HOLD_MIN_CYC);
    localparam logic [pcw_pkg::TIMER_W-1:0] AMAX_T =
        pcw_pkg::TIMER_W'(pcw_pkg::ADDR_HOLD_MAX_CYC);
    localparam logic [pcw_pkg::TIMER_W-1:0] DHOLD_T =
        pcw_pkg::TIMER_W'(pcw_pkg::DATA_HOLD_CYC);
    localparam logic [pcw_pkg::TIMER_W-1:0] BRST_T =
        pcw_pkg::TIMER_W'(pcw_pkg::BUS_RESET_CYC);
    localparam logic [pcw_pkg::TIMER_W-1:0] STBY_T =
        pcw_pkg::TIMER_W'(pcw_pkg::STANDBY_CYC);

    logic sync1_reg;
    logic sync2_reg;
    logic [pcw_pkg::TIMER_W-1:0] stable_cnt;
    logic line_edge;

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= link.single_wire_pin;
            sync2_reg <= sync1_reg;
        end
    end

    pcw_level_timer u_timer (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .level_i(sync2_reg),
        .count_o(stable_cnt),
        .edge_o(line_edge)
    );

    wire rise = line_edge && sync2_reg;
    wire high_now = sync2_reg && !line_edge;

    // ****************************************************************
    // burst decoder
    // ****************************************************************
    pcw_dev_state_t state_reg, state_next;
    logic [pcw_pkg::DATA_W:0] count_reg, count_next;
    logic [pcw_pkg::ADDR_W-1:0] addr_reg, addr_next;
    logic in_burst_reg, in_burst_next;
    logic standby_reg, standby_next;
    logic stb_reg, stb_next;
    logic [pcw_pkg::ADDR_W-1:0] waddr_reg, waddr_next;
    logic [pcw_pkg::DATA_W-1:0] wdata_reg, wdata_next;
    logic [pcw_pkg::DATA_W-1:0] regs_reg [pcw_pkg::NUM_REGS];
    logic [pcw_pkg::DATA_W-1:0] regs_next [pcw_pkg::NUM_REGS];
    logic [pcw_pkg::NUM_LEDS-1:0] float_reg, float_next;

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        addr_next = addr_reg;
        in_burst_next = in_burst_reg;
        standby_next = standby_reg;
        stb_next = 1'b0;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        regs_next = regs_reg;
        float_next = float_reg;
        if (state_reg != PCW_OFF && !sync2_reg && stable_cnt == SHUT_T) begin
            state_next = PCW_OFF;
            for (int i = 0; i < pcw_pkg::NUM_REGS; i++) begin
                regs_next[i] = pcw_pkg::REG_RESET;
            end
            float_next = '0;
            count_next = '0;
            in_burst_next = 1'b0;
            standby_next = 1'b0;
        end else begin
            case (state_reg)
                PCW_OFF: begin
                    if (high_now && stable_cnt == SETUP_T) begin
                        state_next = PCW_ADDR;
                        standby_next = 1'b1;
                    end
                end
                PCW_ADDR, PCW_DATA: begin
                    if (rise) begin
                        // the first rising edge of a burst loads zero, each later one adds one whatever its width, holding at 127
                        count_next = in_burst_reg ? count_reg + 1'b1 : '0;
                        if (in_burst_reg && count_reg == '1) begin
                            count_next = count_reg;
                        end
                        in_burst_next = 1'b1;
                        standby_next = 1'b0;
                    end
                    if (state_reg == PCW_ADDR && in_burst_reg && high_now) begin
                        if (count_reg >= 7'(pcw_pkg::NUM_REGS)) begin
                            state_next = PCW_WAIT_RESET;
                        end else if (stable_cnt == AMIN_T) begin
                            addr_next = count_reg[pcw_pkg::ADDR_W-1:0];
                        end else if (stable_cnt == AMAX_T) begin
                            in_burst_next = 1'b0;
                        end
                    end
                    // address taken once hold passes min; data may begin
                    if (state_reg == PCW_ADDR && in_burst_reg && !sync2_reg
                        && line_edge && count_reg < 7'(pcw_pkg::NUM_REGS)
                        && stable_cnt >= AMIN_T && stable_cnt < AMAX_T) begin
                        state_next = PCW_DATA;
                        count_next = '0;
                        in_burst_next = 1'b0;
                    end
                    if (state_reg == PCW_DATA && in_burst_reg && high_now
                        && stable_cnt == DHOLD_T) begin
                        state_next = PCW_ADDR;
                        in_burst_next = 1'b0;
                        if (count_reg < 7'(1 << pcw_pkg::DATA_W)) begin
                            // write only after the data hold
                            regs_next[addr_reg] = count_reg[pcw_pkg::DATA_W-1:0];
                            stb_next = 1'b1;
                            waddr_next = addr_reg;
                            wdata_next = count_reg[pcw_pkg::DATA_W-1:0];
                            if (addr_reg == pcw_pkg::ADDR_W'(pcw_pkg::LED_EN_ADDR)) begin
                                float_next = '0;
                            end
                        end // else overflow dropped
                    end
                    if (high_now && stable_cnt == STBY_T) begin
                        state_next = PCW_ADDR;
                        in_burst_next = 1'b0;
                        standby_next = 1'b1;
                    end
                end
                PCW_WAIT_RESET: begin
                    if (high_now && stable_cnt == BRST_T) begin
                        state_next = PCW_ADDR;
                        in_burst_next = 1'b0;
                    end
                end
                default: state_next = PCW_OFF;
            endcase
        end
        // a floating enabled output latches off until re-enabled
        float_next = float_next | (led_open_i & regs_reg[pcw_pkg::LED_EN_ADDR]);
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= PCW_OFF;
            count_reg <= '0;
            addr_reg <= '0;
            in_burst_reg <= 1'b0;
            standby_reg <= 1'b0;
            stb_reg <= 1'b0;
            waddr_reg <= '0;
            wdata_reg <= '0;
            float_reg <= '0;
            for (int i = 0; i < pcw_pkg::NUM_REGS; i++) begin
                regs_reg[i] <= pcw_pkg::REG_RESET;
            end
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            addr_reg <= addr_next;
            in_burst_reg <= in_burst_next;
            standby_reg <= standby_next;
            stb_reg <= stb_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            float_reg <= float_next;
            regs_reg <= regs_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // registers untouched while hot, only the drive is blanked
    assign led_drive_o = (overtemp_i || state_reg == PCW_OFF) ? '0
        : regs_reg[pcw_pkg::LED_EN_ADDR] & ~float_reg;
    assign sleep_o = regs_reg[pcw_pkg::LED_EN_ADDR] == '0;
    assign chip_enabled_o = state_reg != PCW_OFF;
    assign standby_o = standby_reg;
    // no read path exists on the wire
    assign write_stb_o = stb_reg;
    assign write_addr_o = waddr_reg;
    assign write_data_o = wdata_reg;
endmodule

// [logic/pcw_host.sv]
// Purpose: host end: turns a write request into two pulse bursts
// Assumes: host drives the wire at all times, high unless pulsing low or off
// Notes: each transaction always resends the address
`timescale 1ns/1ps
module pcw_host (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    pcw_link_if.host link,
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    input wire logic [pcw_pkg::ADDR_W-1:0] wr_addr_i,
    input wire logic [pcw_pkg::DATA_W-1:0] wr_data_i,
    input wire logic enable_i,
    output logic busy_o
);
    typedef enum {
        PCH_OFF,
        PCH_SETUP,
        PCH_IDLE,
        PCH_LOW,
        PCH_HIGH,
        PCH_HOLD
    } pcw_host_state_t;

    localparam logic [pcw_pkg::TIMER_W-1:0] HALF_T =
        pcw_pkg::TIMER_W'(pcw_pkg::PULSE_HALF_CYC);
    localparam logic [pcw_pkg::TIMER_W-1:0] SETUP_T =
        pcw_pkg::TIMER_W'(pcw_pkg::ENABLE_SETUP_CYC + 1);
    // midpoint of the address hold window
    localparam logic [pcw_pkg::TIMER_W-1:0] AHOLD_T =
        pcw_pkg::TIMER_W'((pcw_pkg::ADDR_HOLD_MIN_CYC + pcw_pkg::ADDR_HOLD_MAX_CYC) / 2);
    localparam logic [pcw_pkg::TIMER_W-1:0] DHOLD_T =
        pcw_pkg::TIMER_W'(pcw_pkg::DATA_HOLD_CYC + 8);

    pcw_host_state_t state_reg, state_next;
    logic [pcw_pkg::TIMER_W-1:0] tmr_reg, tmr_next;
    logic [pcw_pkg::DATA_W-1:0] left_reg, left_next;
    logic [pcw_pkg::DATA_W-1:0] data_reg, data_next;
    logic phase_reg, phase_next;

    always_comb begin
        state_next = state_reg;
        tmr_next = tmr_reg + 1'b1;
        left_next = left_reg;
        data_next = data_reg;
        phase_next = phase_reg;
        case (state_reg)
            PCH_OFF: begin
                tmr_next = '0;
                if (enable_i) begin
                    state_next = PCH_SETUP;
                end
            end
            PCH_SETUP: begin
                if (tmr_reg == SETUP_T) begin
                    state_next = PCH_IDLE;
                end
            end
            PCH_IDLE: begin
                tmr_next = '0;
                if (!enable_i) begin
                    state_next = PCH_OFF;
                end else if (wr_valid_i) begin
                    // address always precedes data
                    state_next = PCH_LOW;
                    left_next = pcw_pkg::DATA_W'(wr_addr_i);
                    data_next = wr_data_i;
                    phase_next = 1'b0;
                end
            end
            PCH_LOW: begin
                if (tmr_reg == HALF_T) begin
                    state_next = PCH_HIGH;
                    tmr_next = '0;
                end
            end
            PCH_HIGH: begin
                if (tmr_reg == HALF_T) begin
                    tmr_next = '0;
                    if (left_reg == '0) begin
                        state_next = PCH_HOLD;
                    end else begin
                        state_next = PCH_LOW;
                        left_next = left_reg - 1'b1;
                    end
                end
            end
            PCH_HOLD: begin
                if (!phase_reg && tmr_reg == AHOLD_T) begin
                    state_next = PCH_LOW;
                    tmr_next = '0;
                    left_next = data_reg;
                    phase_next = 1'b1;
                end else if (phase_reg && tmr_reg == DHOLD_T) begin
                    state_next = PCH_IDLE;
                end
            end
            default: state_next = PCH_OFF;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= PCH_OFF;
            tmr_reg <= '0;
            left_reg <= '0;
            data_reg <= '0;
            phase_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            tmr_reg <= tmr_next;
            left_reg <= left_next;
            data_reg <= data_next;
            phase_reg <= phase_next;
        end
    end

    // off holds the wire low, so a long enough off shuts the device down
    logic drive_low;
    assign drive_low = state_reg == PCH_OFF || state_reg == PCH_LOW;
    assign link.wire_oe = 1'b1;
    assign link.wire_out = !drive_low;
    assign wr_ready_o = state_reg == PCH_IDLE && enable_i;
    assign busy_o = state_reg != PCH_IDLE && state_reg != PCH_OFF;
endmodule

// [verification/pcw_link_assertions.sv]
// Purpose: concurrent checks on the device end of the pulse link
// Assumes: one clock domain, wire and device ports as plain inputs
// Notes: high run lengths of the line are counted here, saturating
`timescale 1ns/1ps
module pcw_link_assertions (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic single_wire_pin,
    input wire logic overtemp_i,
    input wire logic [pcw_pkg::NUM_LEDS-1:0] led_open_i,
    input wire logic chip_enabled_o,
    input wire logic sleep_o,
    input wire logic [pcw_pkg::NUM_LEDS-1:0] led_drive_o,
    input wire logic write_stb_o,
    input wire logic [pcw_pkg::ADDR_W-1:0] write_addr_o,
    input wire logic [pcw_pkg::DATA_W-1:0] write_data_o
);
    // ****************************************************************
    // helper state
    // ****************************************************************
    logic [pcw_pkg::TIMER_W-1:0] hi_reg;
    logic [pcw_pkg::TIMER_W-1:0] hi_next;
    logic [1:0] stb_reg;
    logic [1:0] stb_next;
    logic [pcw_pkg::NUM_LEDS-1:0] drv_reg;
    logic [pcw_pkg::NUM_LEDS-1:0] drv_next;

    always_comb begin
        hi_next = hi_reg;
        stb_next = stb_reg;
        drv_next = drv_reg;
        if (!single_wire_pin) begin
            hi_next = '0;
            stb_next = 2'h0;
        end else begin
            // saturate so a long idle high never wraps
            if (hi_reg != '1) begin
                hi_next = hi_reg + 1'b1;
            end
            if (write_stb_o && stb_reg != 2'h3) begin
                stb_next = stb_reg + 2'h1;
            end
        end
        // drive seen just before a hot spell
        if (!overtemp_i) begin
            drv_next = led_drive_o;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hi_reg <= '0;
            stb_reg <= 2'h0;
            drv_reg <= '0;
        end else begin
            hi_reg <= hi_next;
            stb_reg <= stb_next;
            drv_reg <= drv_next;
        end
    end

    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    AST_SLEEP_DARK: assert property (sleep_o |-> led_drive_o == '0)
        else $error("drive active while asleep");
    AST_SLEEP_FOLLOWS: assert property (write_stb_o && write_addr_o == 5'h00
        |-> ##[1:3] sleep_o == (write_data_o == 6'h00))
        else $error("sleep does not follow enable register");
    AST_HOT_BLANK: assert property (overtemp_i |-> led_drive_o == '0)
        else $error("drive active while hot");
    AST_HOT_KEEP: assert property ($fell(overtemp_i) |-> led_drive_o == drv_reg)
        else $error("drive changed across hot spell");
    AST_FLOAT_OFF: assert property ((led_open_i & $past(led_open_i)
        & $past(led_open_i, 2) & led_drive_o) == '0)
        else $error("open output still driven");
    AST_STB_AFTER_HOLD: assert property (write_stb_o
        |-> single_wire_pin && int'(hi_reg) >= pcw_pkg::DATA_HOLD_CYC)
        else $error("write before data hold");
    AST_STB_HELD: assert property (write_stb_o
        |=> !write_stb_o && $stable(write_addr_o) && $stable(write_data_o))
        else $error("write outputs not held");
    AST_EN_LATE: assert property ($rose(chip_enabled_o)
        |-> int'(hi_reg) >= pcw_pkg::ENABLE_SETUP_CYC)
        else $error("enabled before setup time");
    AST_EN_TIMELY: assert property (int'(hi_reg) == pcw_pkg::ENABLE_SETUP_CYC + 8
        |-> chip_enabled_o)
        else $error("not enabled after setup time");
    AST_STB_ENABLED: assert property (write_stb_o |-> chip_enabled_o)
        else $error("write while disabled");
    AST_ONE_PER_HOLD: assert property (stb_reg < 2'h2)
        else $error("two writes in one high period");
endmodule

// [verification/pulse_count_single_wire_writer_test.sv]
// Purpose: end-to-end bench of host and device across the pulse link
// Assumes: full-length package timing, run near 100k cycles
// Notes: a second device on its own wire sees hand-made bursts
`timescale 1ns/1ps
module pulse_count_single_wire_writer_test;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic wr_valid_i = 1'b0;
    logic wr_ready_o;
    logic [pcw_pkg::ADDR_W-1:0] wr_addr_i = 5'h00;
    logic [pcw_pkg::DATA_W-1:0] wr_data_i = 6'h00;
    logic enable_i = 1'b0;
    logic overtemp_i = 1'b0;
    logic [pcw_pkg::NUM_LEDS-1:0] led_open_i = 6'h00;
    logic chip_enabled_o;
    logic sleep_o;
    logic standby_o;
    logic busy_o;
    logic [pcw_pkg::NUM_LEDS-1:0] led_drive_o;
    logic write_stb_o;
    logic [pcw_pkg::ADDR_W-1:0] write_addr_o;
    logic [pcw_pkg::DATA_W-1:0] write_data_o;
    logic f_line = 1'b0;
    logic f_stb;
    logic [pcw_pkg::ADDR_W-1:0] f_addr;
    logic [pcw_pkg::DATA_W-1:0] f_data;
    int fails = 0;
    int n_compared = 0;
    int m_cnt = 0;
    int f_cnt = 0;

    always #20 clk_sys_i = ~clk_sys_i;

    // ****************************************************************
    // ends under test
    // ****************************************************************
    pcw_link_if i_pcw_link_if();
    pcw_link_if i_pcw_link_if_f();
    assign i_pcw_link_if_f.wire_out = f_line;
    assign i_pcw_link_if_f.wire_oe = 1'b1;

    pcw_host i_pcw_host (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .link(i_pcw_link_if),
        .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .wr_addr_i(wr_addr_i),
        .wr_data_i(wr_data_i), .enable_i(enable_i), .busy_o(busy_o));
    pcw_device i_pcw_device (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .link(i_pcw_link_if), .overtemp_i(overtemp_i), .led_open_i(led_open_i),
        .chip_enabled_o(chip_enabled_o), .sleep_o(sleep_o), .standby_o(standby_o),
        .led_drive_o(led_drive_o), .write_stb_o(write_stb_o),
        .write_addr_o(write_addr_o), .write_data_o(write_data_o));
    // fault end: hazards inputs tied, only the wire is exercised here
    pcw_device i_pcw_device_f (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .link(i_pcw_link_if_f), .overtemp_i(1'b0), .led_open_i(6'h00),
        .chip_enabled_o(), .sleep_o(), .standby_o(), .led_drive_o(),
        .write_stb_o(f_stb), .write_addr_o(f_addr), .write_data_o(f_data));
    pcw_link_assertions i_pcw_link_assertions (.clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i), .single_wire_pin(i_pcw_link_if.single_wire_pin),
        .overtemp_i(overtemp_i), .led_open_i(led_open_i),
        .chip_enabled_o(chip_enabled_o), .sleep_o(sleep_o), .led_drive_o(led_drive_o),
        .write_stb_o(write_stb_o), .write_addr_o(write_addr_o),
        .write_data_o(write_data_o));

    always @(negedge clk_sys_i) begin
        if (write_stb_o === 1'b1) begin
            m_cnt++;
        end
        if (f_stb === 1'b1) begin
            f_cnt++;
        end
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // request held until the edge that sees ready high
    task automatic host_write(input logic [4:0] addr, input logic [5:0] data);
        int n;
        n = 0;
        @(negedge clk_sys_i);
        wr_valid_i = 1'b1;
        wr_addr_i = addr;
        wr_data_i = data;
        @(posedge clk_sys_i);
        while (wr_ready_o !== 1'b1 && n < 5000) begin
            @(posedge clk_sys_i);
            n++;
        end
        check(8'(n < 5000), 8'h01, "ready");
        @(negedge clk_sys_i);
        wr_valid_i = 1'b0;
        check({7'h0, busy_o}, 8'h01, "busy");
    endtask

    task automatic wait_write(input int target, input logic [4:0] addr, input logic [5:0] data);
        int n;
        n = 0;
        while (m_cnt < target && n < 60000) begin
            @(negedge clk_sys_i);
            n++;
        end
        check(8'(m_cnt), 8'(target), "write count");
        check({3'h0, write_addr_o}, {3'h0, addr}, "address");
        check({2'h0, write_data_o}, {2'h0, data}, "data");
    endtask

    task automatic f_hold(input logic level, input int cycles);
        f_line = level;
        repeat (cycles) @(negedge clk_sys_i);
    endtask

    task automatic f_burst(input int pulses, input int high);
        repeat (pulses) begin
            f_hold(1'b0, pcw_pkg::PULSE_HALF_CYC + 1);
            f_hold(1'b1, high);
        end
    endtask

    task automatic main_seq();
        repeat (pcw_pkg::ENABLE_SETUP_CYC + 20) @(negedge clk_sys_i);
        check({7'h0, chip_enabled_o}, 8'h01, "enable");
        check({7'h0, standby_o}, 8'h01, "idle standby");
        host_write(5'h00, 6'h05);
        wait_write(1, 5'h00, 6'h05);
        repeat (4) @(negedge clk_sys_i);
        check({7'h0, sleep_o}, 8'h00, "awake");
        check({7'h0, standby_o}, 8'h00, "standby left");
        check({2'h0, led_drive_o}, 8'h05, "drive");
        $display("test first write done");
        overtemp_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        check({2'h0, led_drive_o}, 8'h00, "hot drive");
        overtemp_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        check({2'h0, led_drive_o}, 8'h05, "cooled drive");
        led_open_i = 6'h01;
        repeat (4) @(negedge clk_sys_i);
        check({2'h0, led_drive_o}, 8'h04, "open drive");
        led_open_i = 6'h00;
        repeat (4) @(negedge clk_sys_i);
        check({2'h0, led_drive_o}, 8'h04, "float latched");
        $display("test protection done");
        host_write(5'h01, 6'h00);
        wait_write(2, 5'h01, 6'h00);
        $display("test second write done");
    endtask

    // long hold discards the first burst, short highs keep counting
    task automatic fault_seq();
        f_hold(1'b1, pcw_pkg::ENABLE_SETUP_CYC + 500);
        f_burst(1, pcw_pkg::ADDR_HOLD_MAX_CYC + 1000);
        f_burst(2, 300);
        f_hold(1'b1, (pcw_pkg::ADDR_HOLD_MIN_CYC + pcw_pkg::ADDR_HOLD_MAX_CYC) / 2);
        f_burst(1, pcw_pkg::DATA_HOLD_CYC + 500);
        check(8'(f_cnt), 8'h01, "fault write count");
        check({3'h0, f_addr}, 8'h01, "fault address");
        check({2'h0, f_data}, 8'h00, "fault data");
        $display("test fault wire done");
    endtask

    // ****************************************************************
    // sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (2) @(negedge clk_sys_i);
        reset_n_i = 1'b1;
        check({7'h0, sleep_o}, 8'h01, "sleep after reset");
        check({7'h0, chip_enabled_o}, 8'h00, "off after reset");
        enable_i = 1'b1;
        fork
            main_seq();
            fault_seq();
        join
        complete_run();
    end

    // two full writes take about 95k cycles
    initial begin
        repeat (110000) @(posedge clk_sys_i);
        fails++;
        $display("BAD %0t watchdog expired", $time);
        complete_run();
    end
endmodule
